// ===== hw/klf_pkg.sv
package klf_pkg;
  localparam int KLF_LINES = 8;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] KLF_IDX_LEVEL_SEL = 8'h9c;
  localparam logic [7:0] KLF_IDX_ENABLE = 8'h9d;
  localparam logic [7:0] KLF_IDX_FLAGS = 8'h9e;
  localparam logic [7:0] KLF_IDX_GLOBAL = 8'ha0;
  localparam logic [7:0] KLF_IDX_IRQ_MASK = 8'ha1;
  localparam logic [9:0] KLF_ADDR_LEVEL_SEL = {KLF_IDX_LEVEL_SEL, 2'b00};
  localparam logic [9:0] KLF_ADDR_ENABLE = {KLF_IDX_ENABLE, 2'b00};
  localparam logic [9:0] KLF_ADDR_FLAGS = {KLF_IDX_FLAGS, 2'b00};
  localparam logic [9:0] KLF_ADDR_GLOBAL = {KLF_IDX_GLOBAL, 2'b00};
  localparam logic [9:0] KLF_ADDR_IRQ_MASK = {KLF_IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] KLF_RESET_BYTE = 8'h00;
  // pulled-up idle level of the key lines, loaded into the synchroniser at reset
  localparam logic [7:0] KLF_LINE_IDLE = 8'hff;
  localparam logic [1:0] KLF_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] KLF_HSIZE_WORD = 3'b010;
  // latched address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] addr;
  } klf_aphase_t;
endpackage : klf_pkg

// ===== hw/klf_top.sv
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01: flag bit i set while line at level
// RULE_02: request needs flag and its enable bit
// RULE_03: flag register ignores software writes
// RULE_04: reading flags clears all eight flags; here the read reloads them from live hits, so lines still at level stay set
// RULE_05: enable zero leaves pin plain I/O
// RULE_06: reset clears flags and enables
// RULE_07: eight sources, one global enable gate
// RULE_08: level select zero low, one high
// RULE_09: enabled line event raises wake-up
// RULE_10: lines sampled synchronously, flags re-set
module klf_top import klf_pkg::*; #(
  parameter int LINES = KLF_LINES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [LINES-1:0] keypad_port,
  output logic keypad_irq,
  output logic keypad_wakeup,
  output logic irq
);
  logic [LINES-1:0] sync1_r;
  logic [LINES-1:0] sync2_r;
  logic [LINES-1:0] line_flag_bits_r;
  logic [LINES-1:0] line_irq_enable_bits_r;
  logic [LINES-1:0] line_level_select_r;
  logic keypad_global_irq_enable_r;
  logic irq_mask_r;
  logic irq_sticky_r;
  klf_aphase_t ap_r;
  logic [LINES-1:0] hit;
  logic flag_rd;
  logic wr_en;
  logic [LINES-1:0] req_nxt;

  // two-stage synchroniser; only sync2 is looked at
  // reset to the idle level: zeros would look like every key pressed at low select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= KLF_LINE_IDLE[LINES-1:0];
      sync2_r <= KLF_LINE_IDLE[LINES-1:0];
    end else begin
      sync1_r <= keypad_port; // [RULE_10]
      sync2_r <= sync1_r;
    end
  end

  // a line hits when it equals its selected level
  assign hit = ~(sync2_r ^ line_level_select_r); // [RULE_08]

  // address phase capture; slave is always ready so no wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= '0;
    end else if (hready) begin
      ap_r.valid <= hsel && htrans == KLF_HTRANS_NONSEQ;
      ap_r.write <= hwrite;
      ap_r.addr <= haddr[9:0];
    end
  end

  assign flag_rd = ap_r.valid && !ap_r.write && ap_r.addr == KLF_ADDR_FLAGS;
  assign wr_en = ap_r.valid && ap_r.write;

  // flags: a read clears, but a live hit in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_flag_bits_r <= KLF_RESET_BYTE; // [RULE_06]
    end else if (flag_rd) begin
      line_flag_bits_r <= hit; // [RULE_04] [RULE_10]
    end else begin
      line_flag_bits_r <= line_flag_bits_r | hit; // [RULE_01] [RULE_03]
    end
  end

  // writable control registers; writes to the flag offset fall through
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_irq_enable_bits_r <= KLF_RESET_BYTE; // [RULE_06]
      line_level_select_r <= KLF_RESET_BYTE;
      keypad_global_irq_enable_r <= 1'b0;
      irq_mask_r <= 1'b0;
    end else if (wr_en) begin
      case (ap_r.addr)
        KLF_ADDR_ENABLE: line_irq_enable_bits_r <= hwdata[LINES-1:0];
        KLF_ADDR_LEVEL_SEL: line_level_select_r <= hwdata[LINES-1:0];
        KLF_ADDR_GLOBAL: keypad_global_irq_enable_r <= hwdata[0];
        KLF_ADDR_IRQ_MASK: irq_mask_r <= hwdata[0];
        default: ;
      endcase
    end
  end

  // per-line gating: disabled lines never request
  assign req_nxt = line_flag_bits_r & line_irq_enable_bits_r; // [RULE_02] [RULE_05]

  // request outputs registered; wake-up ignores global enable so idle exit works
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      keypad_irq <= 1'b0;
      keypad_wakeup <= 1'b0;
    end else begin
      keypad_irq <= (|req_nxt) && keypad_global_irq_enable_r; // [RULE_07]
      keypad_wakeup <= |req_nxt; // [RULE_09]
    end
  end

  // sticky status of the shared request, cleared by reading its status word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sticky_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (|req_nxt && keypad_global_irq_enable_r) begin
        irq_sticky_r <= 1'b1;
      end else if (ap_r.valid && !ap_r.write && ap_r.addr == KLF_ADDR_GLOBAL) begin
        irq_sticky_r <= 1'b0;
      end
      irq <= irq_sticky_r && irq_mask_r;
    end
  end

  // read data for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else begin
      hrdata <= '0;
      if (hready && hsel && htrans == KLF_HTRANS_NONSEQ && !hwrite) begin
        case (haddr[9:0])
          KLF_ADDR_FLAGS: hrdata <= {24'h00_0000, line_flag_bits_r | hit};
          KLF_ADDR_ENABLE: hrdata <= {24'h00_0000, line_irq_enable_bits_r};
          KLF_ADDR_LEVEL_SEL: hrdata <= {24'h00_0000, line_level_select_r};
          KLF_ADDR_GLOBAL: hrdata <= {30'h0000_0000, irq_sticky_r, keypad_global_irq_enable_r};
          KLF_ADDR_IRQ_MASK: hrdata <= {31'h0000_0000, irq_mask_r};
          default: hrdata <= '0;
        endcase
      end
    end
  end

  // constant ready and OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  a_flag_clear_read: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_rd |=> line_flag_bits_r == $past(hit)) // [RULE_04]
    else $error("flags not cleared by read");
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    !flag_rd |=> (line_flag_bits_r & $past(line_flag_bits_r)) == $past(line_flag_bits_r))
    else $error("flag lost without read"); // [RULE_03]
  a_flag_set_hit: assert property (@(posedge hclk) disable iff (!hresetn)
    |hit |=> (line_flag_bits_r & $past(hit)) == $past(hit)) // [RULE_01]
    else $error("hit did not set flag");
  a_req_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    keypad_wakeup == $past(|(line_flag_bits_r & line_irq_enable_bits_r))) // [RULE_02]
    else $error("wake-up mismatch");
  a_global_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    keypad_irq |-> $past(keypad_global_irq_enable_r)) // [RULE_07]
    else $error("irq without global enable");
  a_disabled_line: assert property (@(posedge hclk) disable iff (!hresetn)
    line_irq_enable_bits_r == '0 |=> !keypad_wakeup) // [RULE_05]
    else $error("disabled lines requested");
  a_level_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    hit == ~(sync2_r ^ line_level_select_r)) // [RULE_08]
    else $error("level select wrong");
  a_sync_path: assert property (@(posedge hclk) disable iff (!hresetn)
    sync2_r == $past(keypad_port, 2)) // [RULE_10]
    else $error("sync depth wrong");
  a_wake_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    keypad_irq |-> keypad_wakeup) // [RULE_09]
    else $error("irq without wake-up");
  c_flag_read: cover property (@(posedge hclk) flag_rd && |line_flag_bits_r);
  c_irq: cover property (@(posedge hclk) keypad_irq);
  c_sys_irq: cover property (@(posedge hclk) irq);

  // bus side: zero wait states and always OKAY
  a_hready_high: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout == 1'b1)
    else $error("slave inserted a wait state");

  // error response never used
  a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0)
    else $error("slave answered with error");

  // unused read data bits stay zero
  a_rd_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:LINES] == '0)
    else $error("upper read data not zero");

  // a write to the flag word leaves the flags to hardware
  a_flag_write_ign: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_03]
    wr_en && ap_r.addr == KLF_ADDR_FLAGS |=>
      line_flag_bits_r == ($past(line_flag_bits_r) | $past(hit)))
    else $error("software write changed flags");

  // enable register takes the written byte
  a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_05]
    wr_en && ap_r.addr == KLF_ADDR_ENABLE |=>
      line_irq_enable_bits_r == $past(hwdata[LINES-1:0]))
    else $error("enable write lost");

  // level select register takes the written byte
  a_level_write: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_08]
    wr_en && ap_r.addr == KLF_ADDR_LEVEL_SEL |=>
      line_level_select_r == $past(hwdata[LINES-1:0]))
    else $error("level select write lost");

  // global enable bit takes bit zero of the write
  a_global_write: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_07]
    wr_en && ap_r.addr == KLF_ADDR_GLOBAL |=>
      keypad_global_irq_enable_r == $past(hwdata[0]))
    else $error("global enable write lost");

  // a line still at its level survives the clearing read
  a_flag_reread: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_10]
    flag_rd && |hit |=> |line_flag_bits_r)
    else $error("live hit lost by read");

  // no flag rises without a hit behind it
  a_flag_only_hit: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_01]
    1'b1 |=> (line_flag_bits_r & ~$past(line_flag_bits_r) & ~$past(hit)) == '0)
    else $error("flag set without hit");

  // read data of the flag word holds flags and live hits of the address cycle
  a_rd_flag_data: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_04]
    flag_rd |-> hrdata[LINES-1:0] == ($past(line_flag_bits_r) | $past(hit)))
    else $error("flag read data wrong");

  // keypad request needs an enabled flag
  a_irq_need_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_02]
    keypad_irq |-> $past(|(line_flag_bits_r & line_irq_enable_bits_r)))
    else $error("request without enabled flag");

  // keypad request is exactly enabled flags and global enable
  a_irq_exact: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_07]
    keypad_irq == $past(|(line_flag_bits_r & line_irq_enable_bits_r)
      && keypad_global_irq_enable_r))
    else $error("keypad request mismatch");

  // a line with no enable bit cannot wake the core
  a_wake_need_en: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_05]
    keypad_wakeup |-> $past(|line_irq_enable_bits_r))
    else $error("wake-up without enable");

  // wake-up needs a set flag
  a_wake_need_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_09]
    keypad_wakeup |-> $past(|line_flag_bits_r))
    else $error("wake-up without flag");

  // system interrupt only while unmasked
  a_irq_mask_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    irq |-> $past(irq_mask_r))
    else $error("masked interrupt raised");

  // system interrupt only while the status bit stands
  a_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    irq |-> $past(irq_sticky_r))
    else $error("interrupt without status");

  // gated request sets the status bit
  a_sticky_set: assert property (@(posedge hclk) disable iff (!hresetn)
    |req_nxt && keypad_global_irq_enable_r |=> irq_sticky_r)
    else $error("status not set");

  // status bit holds until its word is read
  a_sticky_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_sticky_r && !(ap_r.valid && !ap_r.write && ap_r.addr == KLF_ADDR_GLOBAL)
      |=> irq_sticky_r)
    else $error("status lost without read");

  // first synchroniser stage follows the pin
  a_sync_first: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_10]
    sync1_r == $past(keypad_port))
    else $error("first sync stage wrong");

  // wake-up while the global enable is off
  c_wake_only: cover property (@(posedge hclk) keypad_wakeup && !keypad_irq);
  // software write aimed at the flag word
  c_flag_write: cover property (@(posedge hclk) wr_en && ap_r.addr == KLF_ADDR_FLAGS);
endmodule : klf_top
`default_nettype wire

// ===== testbench/klf_keys.sv
`timescale 1ns/1ps
`default_nettype none
// key matrix lines: a pressed key pulls its line low, pull-ups hold the rest high
module klf_keys (
  input wire logic [7:0] pressed,
  output logic [7:0] keypad_port
);
  // released lines go to the pull-up level, never hold a stale value
  assign keypad_port = ~pressed;
endmodule : klf_keys
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import klf_pkg::*;;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = KLF_HSIZE_WORD;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, keypad_irq, keypad_wakeup, irq;
  logic [7:0] pressed = 0;
  logic [7:0] keypad_port;
  int errors = 0;
  int n_checks = 0;
  // the single slave's hreadyout is the bus's hready
  klf_top u_klf_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .keypad_port,
    .keypad_irq, .keypad_wakeup, .irq);
  klf_keys u_klf_keys (.pressed, .keypad_port);
  initial forever #20 hclk = ~hclk;
  // one single-word transfer; waits for hready in both phases, no fixed latency
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    htrans <= KLF_HTRANS_NONSEQ;
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {22'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // main sequence; 5 cycles covers 3 edges pin-to-flag plus one to the outputs
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(KLF_ADDR_ENABLE, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    rdchk(KLF_ADDR_FLAGS, 32'h0);
    xfer(1'b1, KLF_ADDR_FLAGS, 32'h0000_00ff);
    rdchk(KLF_ADDR_FLAGS, 32'h0);
    rdchk(10'h3fc, 32'h0);
    pressed <= 8'h08;
    repeat (5) @(posedge hclk);
    chk({31'h0, keypad_wakeup}, 32'h0);
    rdchk(KLF_ADDR_FLAGS, 32'h0000_0008);
    rdchk(KLF_ADDR_FLAGS, 32'h0000_0008);
    pressed <= 8'h00;
    repeat (5) @(posedge hclk);
    rdchk(KLF_ADDR_FLAGS, 32'h0000_0008);
    rdchk(KLF_ADDR_FLAGS, 32'h0);
    xfer(1'b1, KLF_ADDR_ENABLE, 32'h0000_0008);
    rdchk(KLF_ADDR_ENABLE, 32'h0000_0008);
    xfer(1'b1, KLF_ADDR_IRQ_MASK, 32'h0000_0001);
    pressed <= 8'h08;
    repeat (5) @(posedge hclk);
    chk({31'h0, keypad_wakeup}, 32'h1);
    chk({31'h0, keypad_irq}, 32'h0);
    xfer(1'b1, KLF_ADDR_GLOBAL, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    chk({31'h0, keypad_irq}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    pressed <= 8'h00;
    repeat (5) @(posedge hclk);
    rdchk(KLF_ADDR_FLAGS, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    chk({31'h0, keypad_irq}, 32'h0);
    rdchk(KLF_ADDR_GLOBAL, 32'h0000_0003);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    // high-level select on an idle line: flag sets, but no enable so no request
    xfer(1'b1, KLF_ADDR_LEVEL_SEL, 32'h0000_0080);
    repeat (5) @(posedge hclk);
    chk({31'h0, keypad_irq}, 32'h0);
    rdchk(KLF_ADDR_FLAGS, 32'h0000_0080);
    complete_run();
  end
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge hclk);
    errors++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
